// ==== hdl/skip_sub_pkg.sv ====
// Package with operation codes, flag positions and reset values for the skip and subtract unit.
package skip_sub_pkg;
  localparam int DATA_W = 8;
  localparam int BIT_SEL_W = 3;
  localparam int OP_W = 3;
  localparam int FLAG_W = 4;
  // Operation codes presented by the decode logic.
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_INC_MEM_SKIP_ZERO = 3'b001,
    OP_INC_TO_WREG_SKIP_ZERO = 3'b010,
    OP_SKIP_BIT_NONZERO = 3'b011,
    OP_SUB_TO_WREG = 3'b100,
    OP_SUBTRACT_TO_MEMORY = 3'b101
  } op_t;
  // Flag vector positions.
  localparam int FLAG_C = 0;
  localparam int FLAG_AC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam logic [7:0] WREG_RESET = 8'h00;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [7:0] MEM_RESET = 8'h00;
  localparam logic [7:0] INC_ONE = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // Execution states: a skip adds exactly one dummy cycle.
  typedef enum logic [0:0] {
    ST_EXEC = 1'b0,
    ST_DUMMY = 1'b1
  } exec_state_t;
endpackage

// ==== hdl/sub_flags_alu.sv ====
// Combinational 8-bit subtractor with overflow, zero, auxiliary carry and carry outputs.
`timescale 1ns/1ps
module sub_flags_alu
  import skip_sub_pkg::*;
(
  // Operands
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  // Results
  output logic [7:0] difference,
  output logic [3:0] flags
);
  wire [8:0] full_diff = {1'b0, minuend} - {1'b0, subtrahend};
  wire [4:0] low_diff = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
  wire sign_ovf = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ full_diff[7]);
  assign difference = full_diff[7:0];
  assign flags[FLAG_OV] = sign_ovf;
  assign flags[FLAG_Z] = (full_diff[7:0] == ZERO_BYTE);
  assign flags[FLAG_AC] = ~low_diff[4];
  assign flags[FLAG_C] = ~full_diff[8];
endmodule

// ==== hdl/skip_and_subtract_exec.sv ====
// Execution unit for increment-and-skip, bit-test skip and subtract instructions.
`timescale 1ns/1ps
module skip_and_subtract_exec
  import skip_sub_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Decode side
  input wire logic op_valid,
  input wire logic [2:0] op_code,
  input wire logic [2:0] bit_sel,
  // Data memory read operand and flags in
  input wire logic [7:0] mem_rdata,
  input wire logic [3:0] flags_in,
  // Results
  output logic [7:0] working_register,
  output logic [3:0] flags_out,
  output logic flags_we,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic dummy_cycle,
  output logic busy
);
  // ----------------------------------------------------------------
  // Decode and datapath
  // ----------------------------------------------------------------
  logic [7:0] wreg_ff, nxt_wreg;
  logic [3:0] flags_ff;
  logic flags_we_ff, mem_we_ff, dummy_ff;
  logic [7:0] mem_wdata_ff;
  exec_state_t state_ff;
  logic [7:0] sub_diff;
  logic [3:0] sub_flags;

  wire accept = op_valid && (state_ff == ST_EXEC);
  wire is_inc_mem = accept && (op_code == OP_INC_MEM_SKIP_ZERO);
  wire is_inc_wreg = accept && (op_code == OP_INC_TO_WREG_SKIP_ZERO);
  wire is_bit_skip = accept && (op_code == OP_SKIP_BIT_NONZERO);
  wire is_sub_wreg = accept && (op_code == OP_SUB_TO_WREG);
  wire is_sub_mem = accept && (op_code == OP_SUBTRACT_TO_MEMORY);
  wire is_sub = is_sub_wreg || is_sub_mem;

  // ----------------------------------------------------------------
  // Increment and bit test
  // ----------------------------------------------------------------
  // increment wraps modulo 256.
  wire [7:0] inc_value = mem_rdata + INC_ONE;
  wire inc_zero = (inc_value == ZERO_BYTE);
  wire bit_set = mem_rdata[bit_sel];
  // skip condition from any skipping instruction.
  // The skip is decided from the operand as read, so no second memory access is needed.
  wire skip_now = ((is_inc_mem || is_inc_wreg) && inc_zero) || (is_bit_skip && bit_set);

  // ----------------------------------------------------------------
  // Subtract datapath
  // ----------------------------------------------------------------
  // The subtractor always sees the live working register, so back-to-back subtracts need no bubble.
  sub_flags_alu u_alu (
    .minuend(wreg_ff),
    .subtrahend(mem_rdata),
    .difference(sub_diff),
    .flags(sub_flags)
  );

  // ----------------------------------------------------------------
  // Result selection
  // ----------------------------------------------------------------
  // increment result to working register; subtract result too.
  assign nxt_wreg = is_inc_wreg ? inc_value : (is_sub_wreg ? sub_diff : wreg_ff);
  // incremented byte goes back to memory; difference goes to memory.
  wire [7:0] nxt_mem_wdata = is_inc_mem ? inc_value : sub_diff;
  wire nxt_mem_we = is_inc_mem || is_sub_mem;
  // only subtracts touch flags; others keep the incoming flags.
  wire [3:0] nxt_flags = is_sub ? sub_flags : flags_in;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // working register load.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wreg_ff <= WREG_RESET;
    end else begin
      wreg_ff <= nxt_wreg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_ff <= FLAGS_RESET;
      flags_we_ff <= 1'b0;
    end else begin
      flags_ff <= nxt_flags;
      flags_we_ff <= is_sub;
    end
  end

  // memory write back.
  // Write data loads every cycle; only the one-cycle strobe makes the memory take it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_wdata_ff <= MEM_RESET;
      mem_we_ff <= 1'b0;
    end else begin
      mem_wdata_ff <= nxt_mem_wdata;
      mem_we_ff <= nxt_mem_we;
    end
  end

  // ----------------------------------------------------------------
  // Skip sequencing
  // ----------------------------------------------------------------
  // An instruction offered in the dummy cycle is the skipped one, so it is dropped, not held.
  // one dummy cycle follows a met skip.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= ST_EXEC;
      dummy_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        ST_EXEC: begin
          state_ff <= skip_now ? ST_DUMMY : ST_EXEC;
          dummy_ff <= skip_now;
        end
        ST_DUMMY: begin
          state_ff <= ST_EXEC;
          dummy_ff <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output ports
  // ----------------------------------------------------------------
  assign working_register = wreg_ff;
  assign flags_out = flags_ff;
  assign flags_we = flags_we_ff;
  assign mem_wdata = mem_wdata_ff;
  assign mem_we = mem_we_ff;
  assign dummy_cycle = dummy_ff;
  assign busy = dummy_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_inc_mem_write: assert property (@(posedge clk) disable iff (!rst_n)
    is_inc_mem |=> mem_we && mem_wdata == $past(mem_rdata) + INC_ONE && !flags_we)
    else $error("increment to memory did not write incremented byte");
  a_skip_one_dummy: assert property (@(posedge clk) disable iff (!rst_n)
    skip_now |=> dummy_cycle ##1 !dummy_cycle)
    else $error("skip did not give exactly one dummy cycle");
  a_no_skip_no_dummy: assert property (@(posedge clk) disable iff (!rst_n)
    (state_ff == ST_EXEC && !skip_now) |=> !dummy_cycle)
    else $error("dummy cycle without a skip");
  a_inc_wreg_load: assert property (@(posedge clk) disable iff (!rst_n)
    is_inc_wreg |=> working_register == $past(mem_rdata) + INC_ONE && !mem_we)
    else $error("increment to register wrong or memory written");
  a_bit_skip_cond: assert property (@(posedge clk) disable iff (!rst_n)
    is_bit_skip |=> dummy_cycle == $past(mem_rdata[bit_sel]) && !flags_we && !mem_we)
    else $error("bit test skip decision wrong");
  a_sub_wreg_result: assert property (@(posedge clk) disable iff (!rst_n)
    is_sub_wreg |=> working_register == $past(wreg_ff) - $past(mem_rdata))
    else $error("subtract to register result wrong");
  a_sub_mem_result: assert property (@(posedge clk) disable iff (!rst_n)
    is_sub_mem |=> mem_we && mem_wdata == $past(wreg_ff) - $past(mem_rdata))
    else $error("subtract to memory result wrong");
  a_sub_carry_flag: assert property (@(posedge clk) disable iff (!rst_n)
    is_sub |=> flags_we && flags_out[FLAG_C] == ($past(wreg_ff) >= $past(mem_rdata)))
    else $error("carry flag wrong after subtract");
  a_sub_zero_flag: assert property (@(posedge clk) disable iff (!rst_n)
    is_sub |=> flags_out[FLAG_Z] == ($past(wreg_ff) == $past(mem_rdata)))
    else $error("zero flag wrong after subtract");

  // ----------------------------------------------------------------
  // Assertions: kept results, flags and reset
  // ----------------------------------------------------------------
  // Sign-extended reference difference; signed overflow shows as its top two bits disagreeing.
  wire [8:0] sext_diff = {wreg_ff[7], wreg_ff} - {mem_rdata[7], mem_rdata};
  a_inc_mem_skip: assert property (@(posedge clk) disable iff (!rst_n)
    is_inc_mem |=> (dummy_cycle == (&$past(mem_rdata))) && $stable(working_register))
    else $error("increment to memory skip or register wrong");
  a_inc_wreg_skip: assert property (@(posedge clk) disable iff (!rst_n)
    is_inc_wreg |=> (dummy_cycle == (&$past(mem_rdata))) && !flags_we)
    else $error("increment to register skip decision wrong");
  a_bit_skip_keep: assert property (@(posedge clk) disable iff (!rst_n)
    is_bit_skip |=> $stable(working_register))
    else $error("bit test skip changed the working register");
  a_sub_wreg_nowrite: assert property (@(posedge clk) disable iff (!rst_n)
    is_sub_wreg |=> !mem_we && !dummy_cycle)
    else $error("subtract to register wrote memory or skipped");
  a_sub_mem_keep: assert property (@(posedge clk) disable iff (!rst_n)
    is_sub_mem |=> $stable(working_register) && !dummy_cycle)
    else $error("subtract to memory changed the working register or skipped");
  a_sub_ovf_flag: assert property (@(posedge clk) disable iff (!rst_n)
    is_sub |=> flags_out[FLAG_OV] == ($past(sext_diff[8]) != $past(sext_diff[7])))
    else $error("overflow flag wrong after subtract");
  a_sub_half_flag: assert property (@(posedge clk) disable iff (!rst_n)
    is_sub |=> flags_out[FLAG_AC] == ($past(wreg_ff[3:0]) >= $past(mem_rdata[3:0])))
    else $error("auxiliary carry wrong after subtract");
  a_flags_untouched: assert property (@(posedge clk) disable iff (!rst_n)
    (accept && !is_sub) |=> !flags_we && flags_out == $past(flags_in))
    else $error("flags written by a non-subtract instruction");
  a_dummy_refused: assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == ST_DUMMY |=> !mem_we && !flags_we && !dummy_cycle && $stable(working_register))
    else $error("request taken during the dummy cycle");
  a_noop_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (!op_valid || op_code == OP_NONE) |=> !mem_we && !flags_we && !dummy_cycle && $stable(working_register))
    else $error("idle or no-op cycle changed state");
  a_reset_values: assert property (@(posedge clk)
    !rst_n |=> working_register == WREG_RESET && flags_out == FLAGS_RESET && !mem_we && !flags_we && !dummy_cycle)
    else $error("outputs not at reset values after reset");
endmodule

// ==== tb/data_mem_model.sv ====
// Behavioural model of the single addressed data memory byte behind the execution unit.
`timescale 1ns/1ps
module data_mem_model (
  // Clock
  input wire logic clk,
  // Bench preload
  input wire logic load,
  input wire logic [7:0] load_val,
  // Write port from the unit
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  // Read operand
  output logic [7:0] mem_rdata
);
  // A preload wins over a write so the bench always knows the operand it set up.
  always_ff @(posedge clk) begin
    if (load) begin
      mem_rdata <= load_val;
    end else if (mem_we) begin
      mem_rdata <= mem_wdata;
    end
  end
endmodule

// ==== tb/skip_and_subtract_exec_tb.sv ====
// Self-checking bench for the skip and subtract execution unit.
`timescale 1ns/1ps
module skip_and_subtract_exec_tb;
  import skip_sub_pkg::*;
  logic clk, rst_n, op_valid, load, flags_we, mem_we, dummy_cycle, busy;
  logic [2:0] op_code, bit_sel;
  logic [7:0] mem_rdata, load_val, working_register, mem_wdata;
  logic [3:0] flags_in, flags_out;
  int errors, total_checks;
  skip_and_subtract_exec i_skip_and_subtract_exec(.clk(clk), .rst_n(rst_n), .op_valid(op_valid),
    .op_code(op_code), .bit_sel(bit_sel), .mem_rdata(mem_rdata), .flags_in(flags_in),
    .working_register(working_register), .flags_out(flags_out), .flags_we(flags_we),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .dummy_cycle(dummy_cycle), .busy(busy));
  data_mem_model i_data_mem_model(.clk(clk), .load(load), .load_val(load_val), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ---------------------------------------------
  // Shared operation driver
  // ---------------------------------------------
  // Preloads the operand, issues one operation and checks the cycle after it is taken.
  // With hold set, the request stays up through the dummy cycle and must be ignored.
  task run_op(input logic [2:0] o, input logic [2:0] b, input logic [7:0] m, input logic hold,
    input logic [7:0] w, input logic [8:0] wr, input logic [4:0] fl, input logic d);
    @(posedge clk);
    load <= 1'b1;
    load_val <= m;
    @(posedge clk);
    load <= 1'b0;
    op_valid <= 1'b1;
    op_code <= o;
    bit_sel <= b;
    @(posedge clk);
    op_valid <= hold;
    #1;
    chk("wreg", 12'(working_register), 12'(w));
    chk("mem", 12'({mem_we, mem_we ? mem_wdata : 8'h00}), 12'(wr));
    chk("flags", 12'({flags_we, flags_out}), 12'(fl));
    chk("dummy", 12'({dummy_cycle, busy}), 12'({d, d}));
    if (hold) begin
      @(posedge clk);
      op_valid <= 1'b0;
      #1;
      chk("refused", 12'({mem_we, dummy_cycle}), 12'h000);
    end
  endtask
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task t_inc_mem;
    run_op(3'h1, 3'h0, 8'hff, 1'b0, 8'h00, 9'h100, 5'h0a, 1'b1);
    run_op(3'h1, 3'h0, 8'h7f, 1'b0, 8'h00, 9'h180, 5'h0a, 1'b0);
  endtask
  task t_inc_wreg;
    run_op(3'h2, 3'h0, 8'h7f, 1'b0, 8'h80, 9'h000, 5'h0a, 1'b0);
    run_op(3'h2, 3'h0, 8'hff, 1'b0, 8'h00, 9'h000, 5'h0a, 1'b1);
  endtask
  task t_bit;
    logic [7:0] pat;
    pat = 8'h5a;
    for (int b = 0; b < 8; b++) begin
      run_op(3'h3, 3'(b), pat, 1'b0, 8'h00, 9'h000, 5'h0a, pat[b]);
    end
  endtask
  task t_sub;
    run_op(3'h2, 3'h0, 8'h04, 1'b0, 8'h05, 9'h000, 5'h0a, 1'b0);
    run_op(3'h4, 3'h0, 8'h07, 1'b0, 8'hfe, 9'h000, 5'h10, 1'b0);
    run_op(3'h5, 3'h0, 8'h7f, 1'b0, 8'hfe, 9'h17f, 5'h19, 1'b0);
    run_op(3'h4, 3'h0, 8'hfe, 1'b0, 8'h00, 9'h000, 5'h17, 1'b0);
  endtask
  task t_refuse;
    run_op(3'h1, 3'h0, 8'hff, 1'b1, 8'h00, 9'h100, 5'h0a, 1'b1);
  endtask
  // Unused codes must leave everything alone while the incoming flags still pass through.
  task t_noop;
    run_op(3'h2, 3'h0, 8'h3c, 1'b0, 8'h3d, 9'h000, 5'h0a, 1'b0);
    @(posedge clk);
    flags_in <= 4'h5;
    run_op(3'h0, 3'h0, 8'h00, 1'b0, 8'h3d, 9'h000, 5'h05, 1'b0);
    run_op(3'h6, 3'h7, 8'hff, 1'b0, 8'h3d, 9'h000, 5'h05, 1'b0);
    run_op(3'h7, 3'h7, 8'hff, 1'b0, 8'h3d, 9'h000, 5'h05, 1'b0);
    @(posedge clk);
    flags_in <= 4'ha;
  endtask
  // A reset in mid-run clears the loaded register and flags, and the unit works right after it.
  task t_reset_mid;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("reset regs", 12'({working_register, flags_out}), 12'h000);
    chk("reset strobes", 12'({mem_we, flags_we, dummy_cycle, busy}), 12'h000);
    run_op(3'h2, 3'h0, 8'h41, 1'b0, 8'h42, 9'h000, 5'h0a, 1'b0);
  endtask
  // Whole run is about eighty cycles; the watchdog allows twenty-five times that.
  initial begin
    #(100 * 2000);
    errors++;
    print_verdict();
  end
  initial begin
    rst_n = 1'b0;
    op_valid = 1'b0;
    op_code = 3'h0;
    bit_sel = 3'h0;
    load = 1'b0;
    load_val = 8'h00;
    flags_in = 4'ha;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_inc_mem();
    t_inc_wreg();
    t_bit();
    t_sub();
    t_refuse();
    t_noop();
    t_reset_mid();
    print_verdict();
  end
endmodule
